// ===== src/retimer_mgmt_end.sv
// retimer management end: straps, role, eeprom load, target reset, irq
// assumes strap levels arrive already quantised to 2 bits per pin
`timescale 1ns/1ps
`default_nettype none
module retimer_mgmt_end
    import strap_load_pkg::*;
#(
    parameter int ROM_DEPTH = ROM_DEPTH_DEF,
    parameter int IRQ_W = IRQ_W_DEF
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    mgmt_link_if.dev LINK,
    input wire logic [1:0] ADDR_LO_LVL_I,
    input wire logic [1:0] ADDR_HI_LVL_I,
    input wire logic [1:0] ROLE_LVL_I,
    input wire logic [IRQ_W-1:0] IRQ_EVENT_I,
    output logic [6:0] DEV_ADDR_O,
    output logic [1:0] ROLE_O,
    output logic STRAP_VALID_O,
    output logic LOGIC_RST_O,
    output logic LOAD_OK_O,
    output logic [ROM_DEPTH*ROM_W-1:0] ROM_IMAGE_O,
    output logic [IRQ_W-1:0] IRQ_MASK_O
);
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_START = 6'h02,
        S_BIT = 6'h04,
        S_ACK = 6'h08,
        S_STOP = 6'h10,
        S_DONE = 6'h20
    } ld_state_t;

    // pin synchronisers
    logic req_s1_q, req_s2_q, sda_s1_q, sda_s2_q, scl_s1_q, scl_s2_q;
    logic [5:0] strap_s1_q, strap_s2_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            req_s1_q <= 1'b1;
            req_s2_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            strap_s1_q <= 6'h00;
            strap_s2_q <= 6'h00;
        end else begin
            req_s1_q <= LINK.load_req_n;
            req_s2_q <= req_s1_q;
            sda_s1_q <= LINK.sda;
            sda_s2_q <= sda_s1_q;
            scl_s1_q <= LINK.mgmt_serial_clock;
            scl_s2_q <= scl_s1_q;
            strap_s1_q <= {ROLE_LVL_I, ADDR_HI_LVL_I, ADDR_LO_LVL_I};
            strap_s2_q <= strap_s1_q;
        end
    end

    // strap capture: straps are static, so one sample once synchronised suffices
    logic strap_valid_q, strap_valid_d;
    logic [1:0] warm_q, warm_d;
    logic [6:0] addr_q, addr_d;
    role_t role_q, role_d;
    always_comb begin
        warm_d = {warm_q[0], 1'b1};
        strap_valid_d = strap_valid_q || warm_q[1];
        addr_d = addr_q;
        role_d = role_q;
        // wait until the synchroniser no longer holds its reset value
        if (!strap_valid_q && warm_q[1]) begin
            addr_d = ADDR_BASE | {3'h0, strap_s2_q[3:0]};
            case (strap_s2_q[5:4])
                LVL_FLOAT: role_d = ROLE_CONTROLLER;
                LVL_STRONG_HI: role_d = ROLE_TARGET;
                default: role_d = ROLE_TEST;
            endcase
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            strap_valid_q <= 1'b0;
            warm_q <= 2'h0;
            addr_q <= ADDR_BASE;
            role_q <= ROLE_TEST;
        end else begin
            strap_valid_q <= strap_valid_d;
            warm_q <= warm_d;
            addr_q <= addr_d;
            role_q <= role_d;
        end
    end
    wire logic is_ctl = strap_valid_q && (role_q == ROLE_CONTROLLER);
    wire logic is_tgt = strap_valid_q && (role_q == ROLE_TARGET);

    // eeprom loader: address byte then sequential read of the image
    ld_state_t st_q, st_d;
    logic [15:0] tick_q, tick_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] idx_q, idx_d;
    logic addr_phase_q, addr_phase_d;
    logic scl_q, scl_d, sda_q, sda_d, ok_q, ok_d, fail_q, fail_d;
    logic [ROM_DEPTH*ROM_W-1:0] img_q, img_d;
    wire logic half = (tick_q == 16'(SCL_HALF_CYC - 1));
    always_comb begin
        st_d = st_q;
        tick_d = half ? 16'h0000 : tick_q + 16'h0001;
        bit_d = bit_q;
        sh_d = sh_q;
        idx_d = idx_q;
        addr_phase_d = addr_phase_q;
        scl_d = scl_q;
        sda_d = sda_q;
        ok_d = ok_q;
        fail_d = fail_q;
        img_d = img_q;
        case (st_q)
            S_IDLE: begin
                tick_d = 16'h0000;
                if (is_ctl && !req_s2_q && !ok_q) begin
                    st_d = S_START;
                    fail_d = 1'b0;
                    sda_d = 1'b0;
                end
            end
            S_START: if (half) begin
                scl_d = 1'b0;
                sh_d = {ROM_ADDR, 1'b1};
                sda_d = ROM_ADDR[ADDR_W-1];
                addr_phase_d = 1'b1;
                bit_d = 4'h0;
                idx_d = 8'h00;
                st_d = S_BIT;
            end
            S_BIT: if (half) begin
                scl_d = !scl_q;
                // data moves only with the clock fall, never while it is high
                if (scl_q) begin
                    sh_d = {sh_q[6:0], scl_s2_q ? sda_s2_q : 1'b0};
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h7) begin
                        st_d = S_ACK;
                        // controller acks every data byte but the last
                        sda_d = addr_phase_q || (idx_q == 8'(ROM_DEPTH - 1));
                    end else sda_d = addr_phase_q ? sh_q[6] : 1'b1; // release while reading
                end
            end
            S_ACK: if (half) begin
                scl_d = !scl_q;
                if (scl_q) begin
                    bit_d = 4'h0;
                    sda_d = 1'b1;
                    if (addr_phase_q) begin
                        addr_phase_d = 1'b0;
                        if (sda_s2_q) begin
                            fail_d = 1'b1; // no eeprom answered
                            sda_d = 1'b0;
                            st_d = S_STOP;
                        end else st_d = S_BIT;
                    end else begin
                        img_d[idx_q*ROM_W +: ROM_W] = sh_q;
                        idx_d = idx_q + 8'h01;
                        sda_d = (idx_q != 8'(ROM_DEPTH - 1)); // stop begins low
                        st_d = (idx_q == 8'(ROM_DEPTH - 1)) ? S_STOP : S_BIT;
                    end
                end
            end
            S_STOP: if (half) begin
                if (!scl_q) sda_d = 1'b0;
                else begin
                    sda_d = 1'b1;
                    st_d = S_DONE;
                end
                scl_d = 1'b1;
            end
            S_DONE: begin
                ok_d = !fail_q;
                st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
        // leaving controller role aborts any load
        if (!is_ctl) begin
            st_d = S_IDLE;
            scl_d = 1'b1;
            sda_d = 1'b1;
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q <= S_IDLE;
            tick_q <= 16'h0000;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            idx_q <= 8'h00;
            addr_phase_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ok_q <= 1'b0;
            fail_q <= 1'b0;
            img_q <= '0;
        end else begin
            st_q <= st_d;
            tick_q <= tick_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            addr_phase_q <= addr_phase_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
            ok_q <= ok_d;
            fail_q <= fail_d;
            img_q <= img_d;
        end
    end

    // irq mask is loaded from the image's first byte, as software would set it
    logic [IRQ_W-1:0] mask_q, mask_d;
    logic done_n_q, done_n_d, irq_q, irq_d;
    always_comb begin
        mask_d = mask_q;
        if (ok_q) mask_d = IRQ_W'(img_q[ROM_W-1:0]);
        if (is_tgt && !req_s2_q) mask_d = '0;
        done_n_d = 1'b1;
        if (is_ctl) done_n_d = !ok_q;
        else if (is_tgt) done_n_d = req_s2_q;
        irq_d = |(IRQ_EVENT_I & mask_q);
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mask_q <= '0;
            done_n_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            done_n_q <= done_n_d;
            irq_q <= irq_d;
        end
    end

    assign LINK.irq_oe = irq_q;
    assign LINK.sda_dev_oe = is_ctl && !sda_q;
    assign LINK.scl_dev_oe = is_ctl && !scl_q;
    assign LINK.load_done_n = done_n_q;
    assign DEV_ADDR_O = addr_q;
    assign ROLE_O = role_q;
    assign STRAP_VALID_O = strap_valid_q;
    assign LOGIC_RST_O = !is_tgt || !req_s2_q;
    assign LOAD_OK_O = ok_q;
    assign ROM_IMAGE_O = img_q;
    assign IRQ_MASK_O = mask_q;
endmodule : retimer_mgmt_end
`default_nettype wire

// ===== shared/strap_load_pkg.sv
// constants and types shared by the retimer management ends
// assumes one 40 MHz clock domain per end
package strap_load_pkg;
    localparam int CLK_HZ = 40000000;
    // strap levels as presented by the pad comparators
    localparam logic [1:0] LVL_STRONG_LO = 2'h0;
    localparam logic [1:0] LVL_WEAK_LO = 2'h1;
    localparam logic [1:0] LVL_FLOAT = 2'h2;
    localparam logic [1:0] LVL_STRONG_HI = 2'h3;
    localparam int ADDR_W = 7;
    // base of the 16-address window; value arbitrary
    localparam logic [6:0] ADDR_BASE = 7'h30;
    localparam int ROM_W = 8;
    localparam int ROM_DEPTH_DEF = 16;
    localparam logic [6:0] ROM_ADDR = 7'h50;
    // serial clock half period
    localparam int SCL_HALF_NS = 5000;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int IRQ_W_DEF = 8;
    typedef enum logic [1:0] {
        ROLE_TEST = 2'h0,
        ROLE_CONTROLLER = 2'h1,
        ROLE_TARGET = 2'h2
    } role_t;
endpackage : strap_load_pkg

// ===== shared/mgmt_link_if.sv
// pin bundle between the retimer management end and its board partner
// assumes pull-ups are resolved here from the enables
`timescale 1ns/1ps
`default_nettype none
interface mgmt_link_if;
    logic sda_dev_oe;
    logic sda_far_oe;
    logic scl_dev_oe;
    logic scl_far_oe;
    logic load_req_n;
    logic load_done_n;
    logic irq_oe;
    logic sda;
    logic mgmt_serial_clock;
    logic irq_n;
    // open-drain nets: any driver pulls low, pull-up otherwise
    assign sda = !(sda_dev_oe || sda_far_oe);
    assign mgmt_serial_clock = !(scl_dev_oe || scl_far_oe);
    assign irq_n = !irq_oe;
    modport dev (
        input sda, mgmt_serial_clock, load_req_n,
        output sda_dev_oe, scl_dev_oe, load_done_n, irq_oe
    );
    modport far (
        input sda, mgmt_serial_clock, load_done_n, irq_n,
        output sda_far_oe, scl_far_oe, load_req_n
    );
endinterface : mgmt_link_if
`default_nettype wire

// ===== src/board_mgmt_end.sv
// board side: drives load request, watches done and irq, serves eeprom bytes
// assumes a simple byte-serving eeprom model is not needed; bytes come from a port
`timescale 1ns/1ps
`default_nettype none
module board_mgmt_end
    import strap_load_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    mgmt_link_if.far LINK,
    input wire logic LOAD_REQ_I,
    input wire logic [7:0] ROM_BYTE_I,
    output logic DONE_O,
    output logic IRQ_O
);
    logic sda_s1_q, sda_s2_q, scl_s1_q, scl_s2_q, scl_old_q, dn1_q, dn2_q, ir1_q, ir2_q;
    logic sda_old_q;
    logic ack_q, ack_d, drv_q, drv_d, act_q, act_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    wire logic fall = scl_old_q && !scl_s2_q;
    always_comb begin
        cnt_d = cnt_q;
        sh_d = sh_q;
        ack_d = ack_q;
        drv_d = drv_q;
        act_d = act_q;
        if (scl_s2_q && !sda_s2_q && sda_old_q) begin
            act_d = 1'b1; // start seen
            // the start's own clock fall wraps this to zero
            cnt_d = 4'hF;
            drv_d = 1'b0;
        end
        if (act_q && fall) begin
            cnt_d = (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
            ack_d = (cnt_q == 4'h7) && !drv_q; // ack address bytes
            if (cnt_q == 4'h8) begin
                // released ninth bit is a nack: stay off the bus until the next start
                drv_d = !sda_old_q;
                act_d = !sda_old_q;
                sh_d = ROM_BYTE_I;
            end else if (drv_q) sh_d = {sh_q[6:0], 1'b1};
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_old_q <= 1'b1;
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_old_q <= 1'b1;
            dn1_q <= 1'b1;
            dn2_q <= 1'b1;
            ir1_q <= 1'b1;
            ir2_q <= 1'b1;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            act_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= 8'hFF;
        end else begin
            sda_s1_q <= LINK.sda;
            sda_s2_q <= sda_s1_q;
            sda_old_q <= sda_s2_q;
            scl_s1_q <= LINK.mgmt_serial_clock;
            scl_s2_q <= scl_s1_q;
            scl_old_q <= scl_s2_q;
            dn1_q <= LINK.load_done_n;
            dn2_q <= dn1_q;
            ir1_q <= LINK.irq_n;
            ir2_q <= ir1_q;
            ack_q <= ack_d;
            drv_q <= drv_d;
            act_q <= act_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
        end
    end
    assign LINK.load_req_n = !LOAD_REQ_I;
    assign LINK.sda_far_oe = ack_q || (drv_q && !sh_q[7] && cnt_q != 4'h8);
    assign LINK.scl_far_oe = 1'b0;
    assign DONE_O = !dn2_q;
    assign IRQ_O = !ir2_q;
endmodule : board_mgmt_end
`default_nettype wire

// ===== test/mgmt_link_asserts.sv
// pin-level checks on the link joining the two management ends
// assumes both ends share one clock and one async high reset
`timescale 1ns/1ps
`default_nettype none
module mgmt_link_asserts (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic sda_dev_oe,
    input wire logic sda_far_oe,
    input wire logic scl_dev_oe,
    input wire logic load_req_n,
    input wire logic load_done_n,
    input wire logic sda,
    input wire logic mgmt_serial_clock
);
    logic [7:0] low_q;
    logic [7:0] low_d;
    // low phases are 200 cycles, so 8 bits never wrap
    always_comb begin
        low_d = mgmt_serial_clock ? 8'h00 : low_q + 8'h01;
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_d;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    a_reset_quiet: assert property ($fell(RST_I) |-> !sda_dev_oe && !scl_dev_oe && load_done_n)
        else $error("link driven right after reset");
    a_done_bus_idle: assert property ($fell(load_done_n) |-> sda && mgmt_serial_clock)
        else $error("done asserted with bus busy");
    a_done_needs_req: assert property ($fell(load_done_n) |-> !$past(load_req_n, 2))
        else $error("done fell without a request");
    a_done_rise_req: assert property ($rose(load_done_n) |-> $past(load_req_n, 2))
        else $error("done rose while request held");
    a_far_data_scl_low: assert property ($changed(sda_far_oe) |-> !mgmt_serial_clock)
        else $error("far data changed with clock high");
    a_low_phase_len: assert property ($rose(mgmt_serial_clock) |-> low_q inside {[8'hC7:8'hC9]})
        else $error("clock low phase length wrong");
    a_start_then_clock: assert property ($rose(sda_dev_oe) && mgmt_serial_clock
        |-> ##[190:210] $fell(mgmt_serial_clock))
        else $error("no clock after start");
    a_quiet_when_done: assert property (!load_done_n |-> !scl_dev_oe && !sda_dev_oe)
        else $error("bus driven after done");
endmodule : mgmt_link_asserts
`default_nettype wire

// ===== test/tb_top.sv
// bench joining both management ends, plus a device end with no acking partner
// assumes 40 MHz clock; load uses a shortened image depth
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import strap_load_pkg::*;
    localparam int DEPTH = 2;
    localparam logic [7:0] ROM_VAL = 8'hA5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] lo_lvl = 2'h0;
    logic [1:0] hi_lvl = 2'h0;
    logic [1:0] role_lvl = 2'h0;
    logic [7:0] irq_ev = 8'h00;
    logic req = 1'b0;
    logic [6:0] dev_addr;
    logic [1:0] role;
    logic valid, core_rst, load_ok, done, irq;
    logic [DEPTH*8-1:0] image;
    logic [7:0] mask;
    logic bad_seen = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;
    mgmt_link_if link ();
    mgmt_link_if bad ();
    always #12.5 clk = ~clk;
    retimer_mgmt_end #(.ROM_DEPTH(DEPTH), .IRQ_W(8)) i_retimer_mgmt_end (
        .CLK_I(clk), .RST_I(rst), .LINK(link), .ADDR_LO_LVL_I(lo_lvl),
        .ADDR_HI_LVL_I(hi_lvl), .ROLE_LVL_I(role_lvl), .IRQ_EVENT_I(irq_ev),
        .DEV_ADDR_O(dev_addr), .ROLE_O(role), .STRAP_VALID_O(valid),
        .LOGIC_RST_O(core_rst), .LOAD_OK_O(load_ok), .ROM_IMAGE_O(image), .IRQ_MASK_O(mask));
    board_mgmt_end i_board_mgmt_end (.CLK_I(clk), .RST_I(rst), .LINK(link),
        .LOAD_REQ_I(req), .ROM_BYTE_I(ROM_VAL), .DONE_O(done), .IRQ_O(irq));
    // partner that never acks, so the load must fail and retry
    retimer_mgmt_end #(.ROM_DEPTH(DEPTH), .IRQ_W(8)) i_retimer_mgmt_end_nack (
        .CLK_I(clk), .RST_I(rst), .LINK(bad), .ADDR_LO_LVL_I(lo_lvl),
        .ADDR_HI_LVL_I(hi_lvl), .ROLE_LVL_I(2'h2), .IRQ_EVENT_I(8'h00),
        .DEV_ADDR_O(), .ROLE_O(), .STRAP_VALID_O(), .LOGIC_RST_O(), .LOAD_OK_O(),
        .ROM_IMAGE_O(), .IRQ_MASK_O());
    mgmt_link_asserts i_mgmt_link_asserts (.CLK_I(clk), .RST_I(rst),
        .sda_dev_oe(link.sda_dev_oe), .sda_far_oe(link.sda_far_oe),
        .scl_dev_oe(link.scl_dev_oe), .load_req_n(link.load_req_n),
        .load_done_n(link.load_done_n), .sda(link.sda),
        .mgmt_serial_clock(link.mgmt_serial_clock));
    initial begin
        bad.sda_far_oe = 1'b0;
        bad.scl_far_oe = 1'b0;
        bad.load_req_n = 1'b0;
    end
    always @(posedge clk) if (!bad.mgmt_serial_clock) bad_seen <= 1'b1;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic restart();
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(3);
    endtask : restart
    task automatic wait_done(input logic lvl, input int lim);
        int k = 0;
        while (link.load_done_n !== lvl && k < lim) begin
            tick(1);
            k++;
        end
        if (k >= lim) begin
            n_errors++;
            wrap_up();
        end
    endtask : wait_done
    initial begin
        tick(3);
        rst = 1'b0;
        tick(2);
        // every address strap combination, role strap swept alongside
        for (int i = 0; i < 16; i++) begin
            lo_lvl = i[1:0];
            hi_lvl = i[3:2];
            role_lvl = i[1:0];
            restart();
            check("addr", dev_addr, ADDR_BASE | 7'(i));
            check("valid", valid, 1'b1);
            check("role", role, (i[1:0] == 2'h2) ? ROLE_CONTROLLER :
                (i[1:0] == 2'h3) ? ROLE_TARGET : ROLE_TEST);
            check("idle done_n", link.load_done_n, 1'b1);
            lo_lvl = ~lo_lvl;
            hi_lvl = ~hi_lvl;
            tick(2);
            check("addr held", dev_addr, ADDR_BASE | 7'(i));
        end
        role_lvl = 2'h3;
        restart();
        for (int i = 1; i < 5; i++) begin
            req = i[0];
            tick(5);
            check("tgt done_n", link.load_done_n, !req);
            check("tgt hold", core_rst, req);
            check("board done", done, req);
            check("tgt clk", link.mgmt_serial_clock, 1'b1);
        end
        role_lvl = 2'h2;
        restart();
        tick(400);
        check("no start", link.mgmt_serial_clock, 1'b1);
        req = 1'b1;
        wait_done(1'b0, 30000);
        tick(4);
        check("load ok", load_ok, 1'b1);
        check("image", image, {DEPTH{ROM_VAL}});
        check("mask", mask, ROM_VAL);
        check("board done", done, 1'b1);
        for (int b = 0; b < 8; b++) begin
            irq_ev = 8'h01 << b;
            tick(6);
            check("irq_n", link.irq_n, !ROM_VAL[b]);
            check("board irq", irq, ROM_VAL[b]);
        end
        irq_ev = 8'h00;
        // a second request after success must not reload
        req = 1'b0;
        tick(5);
        req = 1'b1;
        tick(900);
        check("done kept", link.load_done_n, 1'b0);
        check("no reload", link.mgmt_serial_clock, 1'b1);
        check("nack done_n", bad.load_done_n, 1'b1);
        check("nack tried", bad_seen, 1'b1);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
